// ===== core/css_pkg.sv
// Package of constants, encodings and the register map of the start-up sequencer.
package css_pkg;

  // Clock and internal configuration oscillator rates.
  localparam int unsigned CLK_HZ    = 125_000_000;
  localparam int unsigned OSC_3_HZ  = 3_000_000;
  localparam int unsigned OSC_6_HZ  = 6_000_000;
  localparam int unsigned OSC_12_HZ = 12_000_000;
  localparam int unsigned OSC_25_HZ = 25_000_000;
  localparam int unsigned OSC_CNT_W = 6;

  // Half periods in aclk cycles, rounded down so the rate never falls below the figure.
  localparam logic [5:0] OSC_3_HALF  = 6'(CLK_HZ / (2 * OSC_3_HZ));
  localparam logic [5:0] OSC_6_HALF  = 6'(CLK_HZ / (2 * OSC_6_HZ));
  localparam logic [5:0] OSC_12_HALF = 6'(CLK_HZ / (2 * OSC_12_HZ));
  localparam logic [5:0] OSC_25_HALF = 6'(CLK_HZ / (2 * OSC_25_HZ));

  // Oscillator rate setting codes.
  localparam logic [1:0] RATE_3  = 2'h0;
  localparam logic [1:0] RATE_6  = 2'h1;
  localparam logic [1:0] RATE_12 = 2'h2;
  localparam logic [1:0] RATE_25 = 2'h3;

  // Sequencer clock select codes.
  localparam logic [1:0] SRC_CCLK = 2'h0;
  localparam logic [1:0] SRC_APP  = 2'h1;
  localparam logic [1:0] SRC_TCK  = 2'h2;

  // Idle pin pull setting codes.
  localparam logic [1:0] PULL_DOWN = 2'h0;
  localparam logic [1:0] PULL_UP   = 2'h1;
  localparam logic [1:0] PULL_NONE = 2'h2;

  // Phase field codes.
  localparam logic [2:0] PH_DONE_WAIT = 3'h0;
  localparam logic [2:0] PH_KEEP      = 3'h7;
  localparam logic [2:0] LCK_NO_LOCK_WAIT   = 3'h7;
  localparam logic [2:0] PH_FIRST     = 3'h1;
  localparam logic [2:0] PH_LAST      = 3'h6;
  localparam logic [2:0] DONE_PH_RST  = 3'h4;
  localparam logic [2:0] GTS_PH_RST   = 3'h5;
  localparam logic [2:0] GWE_PH_RST   = 3'h6;

  // Register byte offsets.
  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_CONFIG    = 8'h04;
  localparam logic [7:0]  ADDR_PHASES    = 8'h08;
  localparam logic [7:0]  ADDR_LOCK_MASK = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS    = 8'h10;

  // Control register fields.
  localparam int unsigned CTRL_START = 0;

  // Configuration register fields and reset value.
  localparam int unsigned CFG_RATE_LSB  = 0;
  localparam int unsigned CFG_SRC_LSB   = 2;
  localparam int unsigned CFG_PULL_LSB  = 4;
  localparam int unsigned CFG_DONE_PU   = 6;
  localparam int unsigned CFG_DRIVE_HI  = 7;
  localparam int unsigned CFG_DONE_PIPE = 8;
  localparam int unsigned CFG_EXT_CCLK  = 9;
  localparam int unsigned CFG_W         = 10;
  localparam logic [9:0]  CFG_RST       = 10'h041;

  // Phase register fields.
  localparam int unsigned PH_DONE_LSB = 0;
  localparam int unsigned PH_GWE_LSB  = 4;
  localparam int unsigned PH_GTS_LSB  = 8;
  localparam int unsigned PH_LCK_LSB  = 12;

  // Status register fields.
  localparam int unsigned ST_PHASE_LSB = 0;
  localparam int unsigned ST_RUN       = 4;
  localparam int unsigned ST_USER      = 5;
  localparam int unsigned ST_GWE       = 6;
  localparam int unsigned ST_GTS       = 7;
  localparam int unsigned ST_DONE_REL  = 8;
  localparam int unsigned ST_DONE_IN   = 9;
  localparam int unsigned ST_STALL     = 10;
  localparam int unsigned ST_LOADED    = 11;
  localparam int unsigned ST_LOCK_OK   = 12;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Sequencer states, Gray coded along idle, run, user.
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RUN  = 2'b01,
    SEQ_USER = 2'b11
  } css_seq_t;

  function automatic logic [5:0] osc_half(input logic [1:0] code);
    unique case (code)
      RATE_3:  osc_half = OSC_3_HALF;
      RATE_6:  osc_half = OSC_6_HALF;
      RATE_12: osc_half = OSC_12_HALF;
      RATE_25: osc_half = OSC_25_HALF;
    endcase
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] din, input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = strb[i] ? din[8*i +: 8] : old[8*i +: 8];
    end
    wmerge = old;
  endfunction

endpackage

// ===== core/css_clk_step.sv
// Sequencer clock selection and rising-edge detection producing a one-cycle step enable.
module css_clk_step (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Selection
  input  wire logic [1:0] sel,
  input  wire logic       ext_cclk_sel,
  input  wire logic       osc_rise,
  // Clock pins
  input  wire logic       ext_cclk,
  input  wire logic       app_clk,
  input  wire logic       tck,
  // Step enable
  output logic            step
);

  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] rise;
  logic       cclk_rise;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
    end else begin
      s1_q <= {tck, app_clk, ext_cclk};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Edges are taken between the second and third stages only.
  assign rise      = s2_q & ~s3_q;
  assign cclk_rise = ext_cclk_sel ? rise[0] : osc_rise;

  always_comb begin
    unique case (sel)
      css_pkg::SRC_APP: step = rise[1];
      css_pkg::SRC_TCK: step = rise[2];
      default:          step = cclk_rise;
    endcase
  end

endmodule // css_clk_step

// ===== core/css_sequencer.sv
// Start-up sequencer with oscillator, phase counter, release logic and AXI4-Lite registers.
module css_sequencer #(
  parameter int unsigned N_LOCK = 4
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Sequencer clock sources
  input  wire logic              ext_cclk,
  input  wire logic              app_clk,
  input  wire logic              tck,
  // Clock manager lock indicators
  input  wire logic [N_LOCK-1:0] lock_indicator,
  // Completion pin, open drain unless driven high
  input  wire logic              done_in,
  output logic                   done_out,
  output logic                   done_oe,
  // Oscillator output
  output logic                   cclk_out,
  // Global controls
  output logic                   global_write_enable,
  output logic                   global_three_state,
  // Pull controls
  output logic                   idle_pull_up,
  output logic                   idle_pull_down,
  output logic                   done_pull_up,
  // State
  output logic                   user_mode
);

  // The lock mask word only has room for 32 lock indicators.
  if (N_LOCK < 1 || N_LOCK > 32) begin : g_bad_n_lock
    $error("N_LOCK must lie between 1 and 32");
  end

  // Registers.
  logic [9:0]        cfg_q;
  logic [2:0]        done_ph_q;
  logic [2:0]        gwe_ph_q;
  logic [2:0]        gts_ph_q;
  logic [2:0]        lck_ph_q;
  logic [N_LOCK-1:0] lock_mask_q;
  logic              loaded_q;

  // Bus state.
  logic              aw_have_q;
  logic [7:0]        aw_addr_q;
  logic              w_have_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;

  // Sequencer state.
  css_pkg::css_seq_t seq_q;
  logic [2:0]        phase_q;
  logic [5:0]        osc_cnt_q;
  logic              osc_q;
  logic              gts_hold_q;
  logic              gwe_q;
  logic              done_rel_q;
  logic              done_pipe_q;
  logic [N_LOCK-1:0] lock_s1_q;
  logic [N_LOCK-1:0] lock_s2_q;
  logic              done_s1_q;
  logic              done_s2_q;

  // Write channel decode.
  logic              aw_take;
  logic              w_take;
  logic              wr_go;
  logic [7:0]        wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_ctrl;
  logic              wr_cfg;
  logic              wr_ph;
  logic              wr_mask;
  logic              wr_hit;
  logic [31:0]       cfg_new;
  logic [31:0]       ph_new;
  logic [31:0]       mask_new;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign wr_addr       = aw_have_q ? aw_addr_q : s_axi_awaddr;
  assign wr_data       = w_have_q ? w_data_q : s_axi_wdata;
  assign wr_strb       = w_have_q ? w_strb_q : s_axi_wstrb;
  assign wr_go         = (aw_have_q || aw_take) && (w_have_q || w_take);
  assign wr_ctrl       = wr_go && wr_addr == css_pkg::ADDR_CTRL;
  assign wr_cfg        = wr_go && wr_addr == css_pkg::ADDR_CONFIG;
  assign wr_ph         = wr_go && wr_addr == css_pkg::ADDR_PHASES;
  assign wr_mask       = wr_go && wr_addr == css_pkg::ADDR_LOCK_MASK;
  assign wr_hit        = wr_ctrl || wr_cfg || wr_ph || wr_mask || wr_addr == css_pkg::ADDR_STATUS;
  assign cfg_new       = css_pkg::wmerge({22'h0, cfg_q}, wr_data, wr_strb);
  assign ph_new        = css_pkg::wmerge({17'h0, lck_ph_q, 1'b0, gts_ph_q, 1'b0, gwe_ph_q, 1'b0, done_ph_q},
                                         wr_data, wr_strb);
  assign mask_new      = css_pkg::wmerge(32'(lock_mask_q), wr_data, wr_strb);

  // Configuration fields.
  logic [1:0] rate_sel;
  logic [1:0] src_sel;
  logic [1:0] pull_sel;
  logic [2:0] done_ph_new;
  logic [2:0] gwe_ph_new;
  logic [2:0] gts_ph_new;
  logic [2:0] lck_ph_new;

  assign rate_sel = loaded_q ? cfg_q[css_pkg::CFG_RATE_LSB +: 2] : css_pkg::RATE_3;
  assign src_sel  = cfg_q[css_pkg::CFG_SRC_LSB +: 2];
  assign pull_sel = cfg_q[css_pkg::CFG_PULL_LSB +: 2];

  // Out-of-range completion phases fall back to the nearest legal phase.
  assign done_ph_new = (ph_new[css_pkg::PH_DONE_LSB +: 3] == 3'h0) ? css_pkg::PH_FIRST :
                       (ph_new[css_pkg::PH_DONE_LSB +: 3] == 3'h7) ? css_pkg::PH_LAST :
                       ph_new[css_pkg::PH_DONE_LSB +: 3];
  assign gwe_ph_new  = (ph_new[css_pkg::PH_GWE_LSB +: 3] == css_pkg::PH_KEEP) ? gwe_ph_q :
                       ph_new[css_pkg::PH_GWE_LSB +: 3];
  assign gts_ph_new  = (ph_new[css_pkg::PH_GTS_LSB +: 3] == css_pkg::PH_KEEP) ? gts_ph_q :
                       ph_new[css_pkg::PH_GTS_LSB +: 3];
  assign lck_ph_new  = ph_new[css_pkg::PH_LCK_LSB +: 3];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q       <= css_pkg::CFG_RST;
      done_ph_q   <= css_pkg::DONE_PH_RST;
      gwe_ph_q    <= css_pkg::GWE_PH_RST;
      gts_ph_q    <= css_pkg::GTS_PH_RST;
      lck_ph_q    <= css_pkg::LCK_NO_LOCK_WAIT;
      lock_mask_q <= '0;
      loaded_q    <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg_q    <= cfg_new[css_pkg::CFG_W-1:0];
        loaded_q <= 1'b1;
      end
      if (wr_ph) begin
        done_ph_q <= done_ph_new;
        gwe_ph_q  <= gwe_ph_new;
        gts_ph_q  <= gts_ph_new;
        lck_ph_q  <= lck_ph_new;
      end
      if (wr_mask) begin
        lock_mask_q <= mask_new[N_LOCK-1:0];
      end
    end
  end

  // Write channel handshake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= css_pkg::RESP_OKAY;
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b1;
      bresp_q   <= wr_hit ? css_pkg::RESP_OKAY : css_pkg::RESP_DECERR;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // Synchronisers for lock indicators and completion pin.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_s1_q <= '0;
      lock_s2_q <= '0;
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
    end else begin
      lock_s1_q <= lock_indicator;
      lock_s2_q <= lock_s1_q;
      done_s1_q <= done_in;
      done_s2_q <= done_s1_q;
    end
  end

  // Internal oscillator divider.
  logic osc_tick;
  logic osc_rise;

  assign osc_tick = osc_cnt_q == 6'h00;
  assign osc_rise = osc_tick && !osc_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_cnt_q <= 6'h00;
      osc_q     <= 1'b0;
    end else if (osc_tick) begin
      osc_cnt_q <= css_pkg::osc_half(rate_sel) - 6'h01;
      osc_q     <= !osc_q;
    end else begin
      osc_cnt_q <= osc_cnt_q - 6'h01;
    end
  end

  assign cclk_out = osc_q;

  // Step enable from the selected sequencer clock.
  logic step;

  css_clk_step u_clk_step (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .sel          (src_sel),
    .ext_cclk_sel (cfg_q[css_pkg::CFG_EXT_CCLK]),
    .osc_rise     (osc_rise),
    .ext_cclk     (ext_cclk),
    .app_clk      (app_clk),
    .tck          (tck),
    .step         (step)
  );

  // Phase sequencing.
  logic running;
  logic run_step;
  logic done_sense;
  logic lock_ok;
  logic lock_stall;
  logic gwe_wait;
  logic gts_wait;
  logic done_stall;
  logic advance;
  logic start_req;
  logic gts_rel_d;
  logic gwe_d;

  assign running    = seq_q == css_pkg::SEQ_RUN;
  assign run_step   = running && step;
  assign start_req  = wr_ctrl && wr_strb[0] && wr_data[css_pkg::CTRL_START];
  assign done_sense = cfg_q[css_pkg::CFG_DONE_PIPE] ? done_pipe_q : done_s2_q;
  assign lock_ok    = &(lock_s2_q | ~lock_mask_q);
  assign lock_stall = lck_ph_q != css_pkg::LCK_NO_LOCK_WAIT && phase_q == lck_ph_q && !lock_ok;
  assign gwe_wait   = gwe_ph_q == css_pkg::PH_DONE_WAIT;
  assign gts_wait   = gts_ph_q == css_pkg::PH_DONE_WAIT;
  // The last phase is held until every completion-wait release has happened.
  assign done_stall = phase_q == css_pkg::PH_LAST && (gwe_wait || gts_wait) && !(gwe_d && gts_rel_d);
  assign advance    = run_step && !lock_stall && !done_stall;

  // Release of three-state, then write enable one step later when waiting for completion.
  assign gts_rel_d = gts_wait ? (!gts_hold_q || (run_step && done_sense))
                              : (phase_q >= gts_ph_q);
  assign gwe_d     = gwe_wait ? (gwe_q || (run_step && done_sense && !gts_hold_q))
                              : (phase_q >= gwe_ph_q && running);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_q   <= css_pkg::SEQ_IDLE;
      phase_q <= 3'h0;
    end else begin
      unique case (seq_q)
        css_pkg::SEQ_IDLE: begin
          if (start_req) begin
            seq_q   <= css_pkg::SEQ_RUN;
            phase_q <= 3'h0;
          end
        end
        css_pkg::SEQ_RUN: begin
          if (advance && phase_q == css_pkg::PH_LAST) begin
            seq_q <= css_pkg::SEQ_USER;
          end else if (advance) begin
            phase_q <= phase_q + 3'h1;
          end
        end
        css_pkg::SEQ_USER: begin
          if (start_req) begin
            seq_q   <= css_pkg::SEQ_RUN;
            phase_q <= 3'h0;
          end
        end
        default: begin
          seq_q <= css_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gts_hold_q  <= 1'b1;
      gwe_q       <= 1'b0;
      done_rel_q  <= 1'b0;
      done_pipe_q <= 1'b0;
    end else if (start_req) begin
      gts_hold_q  <= 1'b1;
      gwe_q       <= 1'b0;
      done_rel_q  <= 1'b0;
      done_pipe_q <= 1'b0;
    end else if (running) begin
      gts_hold_q <= !gts_rel_d;
      gwe_q      <= gwe_d;
      done_rel_q <= phase_q >= done_ph_q;
      if (step) begin
        done_pipe_q <= done_s2_q;
      end
    end
  end

  // Completion pin: driven low until release, then floats or drives high.
  assign done_oe  = !done_rel_q || cfg_q[css_pkg::CFG_DRIVE_HI];
  assign done_out = done_rel_q;

  assign global_three_state  = gts_hold_q;
  assign global_write_enable = gwe_q;
  assign user_mode           = seq_q == css_pkg::SEQ_USER;

  // Pull controls; the internal completion pull-up does not replace the board pull-up.
  assign idle_pull_up   = pull_sel == css_pkg::PULL_UP;
  assign idle_pull_down = pull_sel == css_pkg::PULL_DOWN;
  assign done_pull_up   = cfg_q[css_pkg::CFG_DONE_PU];

  // Read channel.
  logic [31:0] status;
  logic [31:0] rd_word;
  logic        rd_hit;

  assign status = {19'h0, lock_ok, loaded_q, (lock_stall || done_stall) && running, done_sense, done_rel_q,
                   !gts_hold_q, gwe_q, user_mode, running, 1'b0, phase_q};
  assign rd_hit = s_axi_araddr == css_pkg::ADDR_CTRL || s_axi_araddr == css_pkg::ADDR_CONFIG ||
                  s_axi_araddr == css_pkg::ADDR_PHASES || s_axi_araddr == css_pkg::ADDR_LOCK_MASK ||
                  s_axi_araddr == css_pkg::ADDR_STATUS;

  always_comb begin
    unique case (s_axi_araddr)
      css_pkg::ADDR_CONFIG:    rd_word = {22'h0, cfg_q};
      css_pkg::ADDR_PHASES:    rd_word = {17'h0, lck_ph_q, 1'b0, gts_ph_q, 1'b0, gwe_ph_q, 1'b0, done_ph_q};
      css_pkg::ADDR_LOCK_MASK: rd_word = 32'(lock_mask_q);
      css_pkg::ADDR_STATUS:    rd_word = status;
      default:                 rd_word = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= css_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_hit ? css_pkg::RESP_OKAY : css_pkg::RESP_DECERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule // css_sequencer

// ===== verification/css_sequencer_asserts.sv
// Port-level checks of the start-up sequencer.
module css_sequencer_asserts (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Sequencer outputs
  input wire logic        cclk_out,
  input wire logic        global_write_enable,
  input wire logic        global_three_state,
  input wire logic        idle_pull_up,
  input wire logic        idle_pull_down,
  input wire logic        user_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channels open while a response waits");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open while data waits");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_gwe_after_gts: assert property ($rose(global_write_enable) |-> !global_three_state)
    else $error("write enable before three-state release");
  chk_pull_exclusive: assert property (!(idle_pull_up && idle_pull_down))
    else $error("idle pins pulled both ways");
  chk_osc_half: assert property ($rose(cclk_out) |-> ##[1:20] !cclk_out)
    else $error("oscillator high too long");
  cover property ($rose(user_mode));
  cover property ($fell(global_three_state));
  cover property ($rose(global_write_enable));
endmodule // css_sequencer_asserts

// ===== verification/css_host_model.sv
// Completion pin on the board: pull-up, the device and a second chained device.
module css_host_model (
  // Device side of the pin
  input  wire logic done_out,
  input  wire logic done_oe,
  // Another chained device still holding the pin low
  input  wire logic hold_low,
  // Level sensed back by the device
  output logic      done_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // The board pull-up wins only when nobody drives low.
  assign done_in = (done_oe ? done_out : 1'b1) & ~hold_low;
endmodule // css_host_model

// ===== verification/css_sequencer_test.sv
// Self-checking bench of the start-up sequencer driven over its register bus.
module css_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn, hold_low, app_clk, tck, ext_cclk, done_in, done_out, done_oe, cclk_out;
  logic        global_write_enable, global_three_state, idle_pull_up, idle_pull_down, done_pull_up, user_mode;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, en, tk;
  logic [3:0]  s_axi_wstrb, lock_indicator;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          h;
  int          rt[4] = '{3, 6, 12, 25};
  css_sequencer u_css_sequencer (.*);
  css_host_model u_css_host_model (.*);
  initial forever #4 aclk = ~aclk;
  // Application, test and external configuration clocks run only while selected, otherwise they stand still.
  always @(posedge aclk) begin
    tk <= tk + 2'h1;
    if (tk == 2'h3) begin
      app_clk <= app_clk ^ (en == 2'h1);
      tck <= tck ^ (en == 2'h2);
      ext_cclk <= ext_cclk ^ (en == 2'h3);
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // Ready follows the response by a cycle, so the slave must hold it meanwhile.
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1));
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), (a > 8'h10) ? 32'h3 : 32'h0);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    check(32'(s_axi_rresp), (a > 8'h10) ? 32'h3 : 32'h0);
  endtask
  // The second high phase is measured, since the first may still run at the old rate.
  task automatic meas(input int mhz);
    repeat (2) begin
      @(posedge cclk_out);
      h = 0;
      @(negedge aclk);
      while (cclk_out === 1'b1) begin
        h++;
        @(negedge aclk);
      end
    end
    check(32'(h), 32'(125 / (2 * mhz)));
  endtask
  task automatic wu();
    for (int i = 0; i < 4000 && user_mode !== 1'b1; i++) @(posedge aclk);
    repeat (4) @(posedge aclk);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge aclk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    {aresetn, hold_low, en, tk, ext_cclk, app_clk, tck, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    lock_indicator = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    meas(3);
    rd(8'h04);
    check(rv, 32'h41);
    rd(8'h08);
    check(rv, 32'h7564);
    rd(8'h14);
    check(rv, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(8'h04, 32'h40 | 32'(i));
      meas(rt[i]);
    end
    for (int p = 0; p < 3; p++) begin
      wr(8'h04, 32'h41 | 32'(p << 4));
      @(negedge aclk);
      check({done_pull_up, idle_pull_up, idle_pull_down}, (p == 0) ? 32'h5 : (p == 1) ? 32'h6 : 32'h4);
    end
    wr(8'h00, 32'h1);
    wu();
    check({global_three_state, global_write_enable, done_oe, user_mode}, 32'h5);
    for (int s = 1; s < 3; s++) begin
      wr(8'h04, 32'h41 | 32'(s << 2));
      wr(8'h00, 32'h1);
      repeat (200) @(posedge aclk);
      check({global_three_state, user_mode}, 32'h2);
      en <= 2'(s);
      wu();
      check(user_mode, 32'h1);
      en <= 2'h0;
    end
    wr(8'h04, 32'h41);
    wr(8'h08, 32'h3564);
    wr(8'h0C, 32'h1);
    lock_indicator <= 4'hE;
    wr(8'h00, 32'h1);
    repeat (600) @(posedge aclk);
    rd(8'h10);
    check(rv & 32'h407, 32'h403);
    lock_indicator <= 4'hF;
    wu();
    check(user_mode, 32'h1);
    wr(8'h08, 32'h7004);
    wr(8'h04, 32'h1C1);
    hold_low <= 1'b1;
    wr(8'h00, 32'h1);
    repeat (600) @(posedge aclk);
    check({global_three_state, global_write_enable, done_oe, done_out}, 32'hB);
    hold_low <= 1'b0;
    wu();
    check({global_three_state, global_write_enable, user_mode}, 32'h3);
    wr(8'h08, 32'h7774);
    hold_low <= 1'b1;
    wr(8'h00, 32'h1);
    repeat (600) @(posedge aclk);
    check({global_three_state, global_write_enable}, 32'h2);
    hold_low <= 1'b0;
    wu();
    check(global_write_enable, 32'h1);
    // External configuration clock: the internal oscillator would step within this wait.
    wr(8'h14, 32'h0);
    wr(8'h04, 32'h201);
    wr(8'h00, 32'h1);
    repeat (200) @(posedge aclk);
    check({done_pull_up, user_mode}, 32'h0);
    en <= 2'h3;
    wu();
    check({global_write_enable, user_mode}, 32'h3);
    en <= 2'h0;
    complete_run();
  end
endmodule // css_sequencer_test
bind css_sequencer css_sequencer_asserts u_css_sequencer_asserts (.*);
